// ---- rtl/clk_gate_pkg.sv ----
// package: offsets, field positions, reset values and types of the sleep clock gating block
package clk_gate_pkg;

    localparam int ADDR_W = 12;
    localparam int NUM_UNITS = 7;

    // register offsets (byte addresses)
    localparam logic [ADDR_W-1:0] RUN_GATE_OFF = 12'h104;
    localparam logic [ADDR_W-1:0] SLEEP_GATE_OFF = 12'h114;
    localparam logic [ADDR_W-1:0] DEEP_GATE_OFF = 12'h124;
    localparam logic [ADDR_W-1:0] RUN_CLOCK_CFG_OFF = 12'h060;
    localparam logic [ADDR_W-1:0] IRQ_STATUS_OFF = 12'h200;
    localparam logic [ADDR_W-1:0] IRQ_MASK_OFF = 12'h204;
    localparam logic [ADDR_W-1:0] POWER_STATE_OFF = 12'h208;

    // enable field positions
    localparam int ASYNC_SERIAL_ZERO_POS = 0;
    localparam int SYNC_SERIAL_ZERO_POS = 4;
    localparam int GP_COUNTER_ZERO_POS = 16;
    localparam int GP_COUNTER_ONE_POS = 17;
    localparam int GP_COUNTER_TWO_POS = 18;
    localparam int COMPARATOR_ZERO_POS = 24;
    localparam int COMPARATOR_ONE_POS = 25;

    // writable bits of the gating registers; the rest read as zero
    localparam logic [31:0] GATE_WRITE_MASK = 32'h0307_0011;
    localparam logic [31:0] GATE_RESET = 32'h0000_0000;

    // auto gating select position in the run clock configuration register
    localparam int AUTO_GATING_SELECT_POS = 27;
    localparam logic [31:0] RUN_CLOCK_CFG_RESET = 32'h0000_0000;

    // interrupt status bit positions
    localparam int IRQ_FAULT_POS = 0;
    localparam int IRQ_STATE_POS = 1;
    localparam logic [1:0] IRQ_RESET = 2'h0;

    // unit index to register bit position
    localparam int UNIT_POS [NUM_UNITS] = '{
        ASYNC_SERIAL_ZERO_POS, SYNC_SERIAL_ZERO_POS, GP_COUNTER_ZERO_POS,
        GP_COUNTER_ONE_POS, GP_COUNTER_TWO_POS, COMPARATOR_ZERO_POS,
        COMPARATOR_ONE_POS
    };

    typedef enum logic [1:0] {
        PWR_RUN,
        PWR_SLEEP,
        PWR_DEEP_SLEEP
    } power_state_type;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } reg_req_type;

    typedef struct packed {
        logic valid;
        logic [NUM_UNITS-1:0] sel;
    } unit_access_type;

endpackage

// ---- rtl/sleep_clock_gating_ctl.sv ----
// sleep-mode peripheral clock gating control with run and deep-sleep companions
//
// Functional notes
// RULE1: each writable gating bit is the clock enable of one peripheral unit.
// RULE2: access to a unit whose clock is gated off returns a bus fault.
// RULE3: reset loads zero into the sleep gating register; all units unclocked.
// RULE4: software must enable every unit it needs; nothing is clocked after reset.
// RULE5: run, sleep and deep-sleep registers apply by current power state.
// RULE6: sleep and deep-sleep registers apply only with auto gating select set.
// RULE7: bits 18, 17, 16 enable general-purpose counters 2, 1, 0.
// RULE8: bit 4 enables synchronous serial unit 0.
// RULE9: bit 0 enables asynchronous serial unit 0.
// RULE10: bits 31:26, 23:19, 15:5, 3:1 are read-only zero.
// RULE11: bits 25, 24 enable analog comparators 1 and 0.
`timescale 1ns/1ps

module sleep_clock_gating_ctl
    import clk_gate_pkg::*;
(
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_i,
    // register port
    input wire clk_gate_pkg::reg_req_type reg_req_i,
    output logic [31:0] reg_rdata_o,
    // power state from the system controller
    input wire clk_gate_pkg::power_state_type power_state_i,
    // peripheral bus access watch
    input wire clk_gate_pkg::unit_access_type unit_access_i,
    output logic bus_fault_o,
    // clock enables to the peripheral units
    output logic [NUM_UNITS-1:0] unit_clk_en_o,
    // interrupt
    output logic irq_o
);
    import clk_gate_pkg::*;

    logic [31:0] run_gate_reg_one_q;
    logic [31:0] sleep_gate_reg_one_q;
    logic [31:0] deep_sleep_gate_reg_one_q;
    logic [31:0] run_clock_config_reg_q;
    logic [1:0] irq_status_q;
    logic [1:0] irq_status_d;
    logic [1:0] irq_mask_q;
    logic [31:0] gate_sel;
    logic [31:0] rdata_d;
    logic auto_gating_select;
    logic fault_d;
    logic state_change;
    logic wr_run;
    logic wr_sleep;
    logic wr_deep;
    logic wr_cfg;
    logic wr_mask;
    logic rd_status;
    logic [NUM_UNITS-1:0] en_pick;
    logic [NUM_UNITS-1:0] gated_hit;
    power_state_type power_state_q;

    assign auto_gating_select = run_clock_config_reg_q[AUTO_GATING_SELECT_POS];

    // one decoder for all write strobes keeps the address map in one place
    always_comb begin
        wr_run = 1'b0;
        wr_sleep = 1'b0;
        wr_deep = 1'b0;
        wr_cfg = 1'b0;
        wr_mask = 1'b0;
        if (reg_req_i.wr) begin
            unique case (reg_req_i.addr)
                RUN_GATE_OFF: begin
                    wr_run = 1'b1;
                end
                SLEEP_GATE_OFF: begin
                    wr_sleep = 1'b1;
                end
                DEEP_GATE_OFF: begin
                    wr_deep = 1'b1;
                end
                RUN_CLOCK_CFG_OFF: begin
                    wr_cfg = 1'b1;
                end
                IRQ_MASK_OFF: begin
                    wr_mask = 1'b1;
                end
                default: begin
                    // unmapped writes are dropped without a trace
                end
            endcase
        end
    end

    // reading the status register is what clears it
    assign rd_status = reg_req_i.rd && (reg_req_i.addr == IRQ_STATUS_OFF);

    // gating registers; only documented enable bits are stored
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            run_gate_reg_one_q <= GATE_RESET;
        end else if (wr_run) begin
            run_gate_reg_one_q <= reg_req_i.wdata & GATE_WRITE_MASK; // RULE10
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            sleep_gate_reg_one_q <= GATE_RESET; // RULE3
        end else if (wr_sleep) begin
            sleep_gate_reg_one_q <= reg_req_i.wdata & GATE_WRITE_MASK; // RULE10
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            deep_sleep_gate_reg_one_q <= GATE_RESET;
        end else if (wr_deep) begin
            deep_sleep_gate_reg_one_q <= reg_req_i.wdata & GATE_WRITE_MASK; // RULE10
        end
    end

    // only the auto gating select bit is implemented here
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            run_clock_config_reg_q <= RUN_CLOCK_CFG_RESET;
        end else if (wr_cfg) begin
            run_clock_config_reg_q <= '0;
            run_clock_config_reg_q[AUTO_GATING_SELECT_POS] <=
                reg_req_i.wdata[AUTO_GATING_SELECT_POS];
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            irq_mask_q <= IRQ_RESET;
        end else if (wr_mask) begin
            irq_mask_q <= reg_req_i.wdata[1:0];
        end
    end

    // register the power state so gating changes land on a clean edge
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            power_state_q <= PWR_RUN;
        end else begin
            power_state_q <= power_state_i;
        end
    end

    // pick the gating register for the current power state
    always_comb begin
        gate_sel = run_gate_reg_one_q;
        if (auto_gating_select) begin // RULE6
            unique case (power_state_q) // RULE5
                PWR_RUN: begin
                    gate_sel = run_gate_reg_one_q;
                end
                PWR_SLEEP: begin
                    gate_sel = sleep_gate_reg_one_q;
                end
                PWR_DEEP_SLEEP: begin
                    gate_sel = deep_sleep_gate_reg_one_q;
                end
                default: begin
                    // the unused state code keeps the running set alive
                    gate_sel = run_gate_reg_one_q;
                end
            endcase
        end
    end

    // one column per unit: its enable bit and whether an access finds it gated
    genvar gi;
    generate
        for (gi = 0; gi < NUM_UNITS; gi++) begin : g_unit
            // field position of this unit, shared by all three gating registers
            assign en_pick[gi] = gate_sel[UNIT_POS[gi]]; // RULE7 RULE8 RULE9 RULE11
            // an unclocked unit cannot answer, so its access must fault
            assign gated_hit[gi] = unit_access_i.sel[gi] && !unit_clk_en_o[gi]; // RULE2
        end
    endgenerate

    // enables come from flip-flops so no glitch reaches a clock gate
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            unit_clk_en_o <= '0; // RULE3
        end else begin
            unit_clk_en_o <= en_pick; // RULE1
        end
    end

    // any selected unit with its clock off faults the access
    always_comb begin
        fault_d = unit_access_i.valid && (gated_hit != '0); // RULE2
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            bus_fault_o <= 1'b0;
        end else begin
            bus_fault_o <= fault_d; // RULE2
        end
    end

    assign state_change = (power_state_i != power_state_q);

    // sticky events; a new event wins over the read that clears
    always_comb begin
        irq_status_d = irq_status_q;
        if (rd_status) begin
            irq_status_d = '0;
        end
        if (fault_d) begin
            irq_status_d[IRQ_FAULT_POS] = 1'b1;
        end
        if (state_change) begin
            irq_status_d[IRQ_STATE_POS] = 1'b1;
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            irq_status_q <= IRQ_RESET;
        end else begin
            irq_status_q <= irq_status_d;
        end
    end

    assign irq_o = |(irq_status_q & irq_mask_q);

    // read mux; unmapped addresses read zero
    always_comb begin
        rdata_d = '0;
        unique case (reg_req_i.addr)
            RUN_GATE_OFF: begin
                rdata_d = run_gate_reg_one_q;
            end
            SLEEP_GATE_OFF: begin
                rdata_d = sleep_gate_reg_one_q; // RULE10
            end
            DEEP_GATE_OFF: begin
                rdata_d = deep_sleep_gate_reg_one_q;
            end
            RUN_CLOCK_CFG_OFF: begin
                rdata_d = run_clock_config_reg_q;
            end
            IRQ_STATUS_OFF: begin
                rdata_d = {30'h0, irq_status_q};
            end
            IRQ_MASK_OFF: begin
                rdata_d = {30'h0, irq_mask_q};
            end
            POWER_STATE_OFF: begin
                // the registered state is shown, the one gating really uses
                rdata_d = {30'h0, power_state_q};
            end
            default: begin
                rdata_d = '0;
            end
        endcase
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            reg_rdata_o <= '0;
        end else if (reg_req_i.rd) begin
            reg_rdata_o <= rdata_d;
        end else begin
            reg_rdata_o <= '0;
        end
    end

endmodule

// ---- tb/clk_gate_assertions.sv ----
// checker: port-level assertions and covers for the sleep clock gating block
`timescale 1ns/1ps
module clk_gate_checker
    import clk_gate_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire clk_gate_pkg::reg_req_type reg_req_i,
    input wire logic [31:0] reg_rdata_o,
    input wire clk_gate_pkg::power_state_type power_state_i,
    input wire clk_gate_pkg::unit_access_type unit_access_i,
    input wire logic bus_fault_o,
    input wire logic [NUM_UNITS-1:0] unit_clk_en_o,
    input wire logic irq_o
);
    logic auto_q;
    logic hit;
    function automatic logic [NUM_UNITS-1:0] pick(logic [31:0] w);
        return {w[25], w[24], w[18], w[17], w[16], w[4], w[0]};
    endfunction
    assign hit = unit_access_i.valid && |(unit_access_i.sel & ~unit_clk_en_o);
    // shadow of auto gating select, so run-register writes can be judged alone
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            auto_q <= 1'b0;
        end else if (reg_req_i.wr && reg_req_i.addr == RUN_CLOCK_CFG_OFF) begin
            auto_q <= reg_req_i.wdata[AUTO_GATING_SELECT_POS];
        end
    end
    default clocking @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    AST_FAULT: assert property (hit |=> bus_fault_o)
        else $error("no bus fault for gated unit");
    AST_NO_FAULT: assert property (!hit |=> !bus_fault_o)
        else $error("bus fault without gated access");
    AST_RESET_EN: assert property ($fell(rst_i) |-> unit_clk_en_o == '0 ##1 unit_clk_en_o == '0)
        else $error("enables not zero after reset");
    AST_RD_IDLE: assert property (!reg_req_i.rd |=> reg_rdata_o == 32'h0)
        else $error("read data outside read cycle");
    AST_RSVD: assert property (reg_req_i.rd && reg_req_i.addr == SLEEP_GATE_OFF
        |=> (reg_rdata_o & ~GATE_WRITE_MASK) == 32'h0)
        else $error("reserved sleep bits not zero");
    AST_RUN_MAP: assert property (reg_req_i.wr && reg_req_i.addr == RUN_GATE_OFF && !auto_q
        |=> ##1 unit_clk_en_o == pick($past(reg_req_i.wdata, 2)))
        else $error("enables do not follow run register");
    AST_EN_CAUSE: assert property ($changed(unit_clk_en_o) |-> $past(reg_req_i.wr, 2)
        || $past(power_state_i, 2) != $past(power_state_i, 3))
        else $error("enables changed without cause");
    AST_STATUS_CLR: assert property (reg_req_i.rd && reg_req_i.addr == IRQ_STATUS_OFF && !hit
        && power_state_i == $past(power_state_i) |=> !irq_o)
        else $error("interrupt stays after status read");
    COV_FAULT: cover property (hit ##1 bus_fault_o);
    COV_IRQ: cover property ($rose(irq_o));
    COV_ALL_EN: cover property (unit_clk_en_o == 7'h7f);
endmodule

bind sleep_clock_gating_ctl clk_gate_checker u_clk_gate_checker (.mclk_i(mclk_i),
    .rst_i(rst_i), .reg_req_i(reg_req_i), .reg_rdata_o(reg_rdata_o),
    .power_state_i(power_state_i), .unit_access_i(unit_access_i),
    .bus_fault_o(bus_fault_o), .unit_clk_en_o(unit_clk_en_o), .irq_o(irq_o));

// ---- tb/sleep_clock_gating_ctl_tb.sv ----
// testbench: register-port tests of the sleep clock gating block
`timescale 1ns/1ps
module sleep_clock_gating_ctl_tb;
    import clk_gate_pkg::*;
    logic mclk_i = 1'b0;
    logic rst_i = 1'b1;
    reg_req_type req = '0;
    power_state_type pstate = PWR_RUN;
    unit_access_type acc = '0;
    logic [31:0] rdata;
    logic fault;
    logic [NUM_UNITS-1:0] en;
    logic irq;
    int err_count = 0;
    int n_compared = 0;
    int cyc = 0;
    sleep_clock_gating_ctl u_sleep_clock_gating_ctl (.mclk_i(mclk_i), .rst_i(rst_i),
        .reg_req_i(req), .reg_rdata_o(rdata), .power_state_i(pstate),
        .unit_access_i(acc), .bus_fault_o(fault), .unit_clk_en_o(en), .irq_o(irq));
    initial begin
        forever #2 mclk_i = ~mclk_i;
    end
    task automatic settle(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask
    task automatic chk(input logic [31:0] e, input logic [31:0] g, input string n);
        n_compared++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge mclk_i);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge mclk_i);
        req <= '0;
    endtask
    // read data stand only in the cycle after the strobe, so sample there
    task automatic rd_reg(input logic [ADDR_W-1:0] a, input logic [31:0] e, input string n);
        @(posedge mclk_i);
        req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge mclk_i);
        req <= '0;
        #1 chk(e, rdata, n);
    endtask
    task automatic access(input logic [NUM_UNITS-1:0] s, input logic e);
        @(posedge mclk_i);
        acc <= '{valid: 1'b1, sel: s};
        @(posedge mclk_i);
        #1 chk(e, fault, "fault");
        @(posedge mclk_i);
        acc <= '0;
    endtask
    task automatic set_state(input power_state_type s);
        @(posedge mclk_i);
        pstate <= s;
        settle(3);
    endtask
    task automatic give_verdict();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    always @(posedge mclk_i) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            err_count++;
            give_verdict();
        end
    end
    initial begin
        repeat (6) @(posedge mclk_i);
        rst_i <= 1'b0;
        settle(1);
        chk(32'h0, en, "reset en");
        rd_reg(SLEEP_GATE_OFF, GATE_RESET, "reset sleep");
        wr_reg(RUN_GATE_OFF, 32'h0000_0011);
        wr_reg(SLEEP_GATE_OFF, 32'hffff_ffff);
        rd_reg(SLEEP_GATE_OFF, 32'h0307_0011, "sleep bits");
        set_state(PWR_SLEEP);
        chk(32'h03, en, "sleep no auto");
        wr_reg(RUN_CLOCK_CFG_OFF, 32'h0800_0000);
        settle(2);
        chk(32'h7f, en, "sleep auto");
        $display("test gating select done");
        for (int i = 0; i < NUM_UNITS; i++) begin
            wr_reg(SLEEP_GATE_OFF, 32'h1 << UNIT_POS[i]);
            settle(2);
            chk(32'h1 << i, en, "unit map");
            access(~(7'h1 << i), 1'b1);
            access(7'h1 << i, 1'b0);
        end
        $display("test unit map done");
        set_state(PWR_DEEP_SLEEP);
        chk(32'h0, en, "deep");
        wr_reg(DEEP_GATE_OFF, 32'h0100_0000);
        settle(2);
        chk(32'h20, en, "deep comp");
        rd_reg(POWER_STATE_OFF, 32'h2, "pstate deep");
        rd_reg(DEEP_GATE_OFF, 32'h0100_0000, "deep reg");
        rd_reg(RUN_GATE_OFF, 32'h0000_0011, "run reg");
        rd_reg(RUN_CLOCK_CFG_OFF, 32'h0800_0000, "cfg reg");
        set_state(PWR_RUN);
        chk(32'h03, en, "run");
        rd_reg(12'h300, 32'h0, "unmapped");
        $display("test power states done");
        wr_reg(IRQ_MASK_OFF, 32'h1);
        settle(1);
        chk(32'h1, irq, "irq");
        rd_reg(IRQ_STATUS_OFF, 32'h3, "status");
        settle(1);
        chk(32'h0, irq, "irq clr");
        wr_reg(IRQ_MASK_OFF, 32'h0);
        access(7'h7c, 1'b1);
        chk(32'h0, irq, "irq masked");
        wr_reg(IRQ_MASK_OFF, 32'h1);
        settle(1);
        chk(32'h1, irq, "irq unmask");
        $display("test interrupt done");
        give_verdict();
    end
endmodule
